// File: hw/ufmc_top.sv
/*
  Serial frame mode controller: receiver with polarity select, 4x/16x
  oversampling, rate measurement on a sync character, selectable frame
  format, sleep handling and a two-entry receive buffer; a matching
  transmitter. Assumes SLEEP comes from the power manager on CLK and
  the serial input arrives asynchronously.
*/
// Overview of operation
// - Inversion bit set makes low the receive pin's idle level.
// - Start bit is the level opposite idle.
// - Rate enable measures next character, a 55h sync.
// - Hardware clears rate enable when measurement completes.
// - Fast bit gives 4 ticks, else 16.
// - Format field picks nine, odd, even, plain eight.
// - Sleep halts the baud sampling clock.
// - First character after wake is flagged invalid.
`timescale 1ns/1ps
module ufmc_top #(
  parameter logic [15:0] RESET_DIVISOR = 16'h0001
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic SLEEP,
  input wire logic [ufmc_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic SERIAL_RECEIVE_PIN,
  output logic SERIAL_TRANSMIT_PIN
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (RESET_DIVISOR == 16'h0000)
  begin : g_chk
    $error("RESET_DIVISOR must be nonzero");
  end

  ufmc_pkg::ufmc_state_t r_reg, r_next;

  // Merges a write into a 16-bit register under the byte enables.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    merge16 = old;
    if (be[0])
    begin
      merge16[7:0] = wd[7:0];
    end
    if (be[1])
    begin
      merge16[15:8] = wd[15:8];
    end
  endfunction

  logic line;
  logic tick;
  logic [4:0] os;
  logic [1:0] pd;
  logic [3:0] nbits;
  logic par_on;
  logic req;
  logic accept;
  logic push;
  logic pop;
  logic ab_on;
  ufmc_pkg::ufmc_word_t word;

  always_comb
  begin
    r_next = r_reg;
    word = '0;
    push = 1'b0;
    // ---------------------------------------------------------------
    // Pin input and mode decode
    // ---------------------------------------------------------------
    r_next.sync1 = SERIAL_RECEIVE_PIN;
    r_next.sync2 = r_reg.sync1;
    line = r_reg.sync2 ^ r_reg.mode[ufmc_pkg::BIT_RXINV];
    r_next.line_prev = line;
    os = r_reg.mode[ufmc_pkg::BIT_FAST_OVERSAMPLE_SEL] ? ufmc_pkg::OS_FAST : ufmc_pkg::OS_STD;
    pd = r_reg.mode[ufmc_pkg::PARITY_WIDTH_SEL_LO +: 2];
    nbits = (pd == ufmc_pkg::PD_NINE) ? 4'h9 : 4'h8;
    par_on = (pd == ufmc_pkg::PD_ODD) || (pd == ufmc_pkg::PD_EVEN);
    ab_on = r_reg.mode[ufmc_pkg::BIT_AUTO_RATE_MEASURE_EN];

    // ---------------------------------------------------------------
    // Baud generator, halted in sleep
    // ---------------------------------------------------------------
    tick = 1'b0;
    if (!SLEEP)
    begin
      if (r_reg.bcnt == 16'h0000)
      begin
        tick = 1'b1;
        r_next.bcnt = r_reg.div - 16'h0001;
      end
      else
      begin
        r_next.bcnt = r_reg.bcnt - 16'h0001;
      end
    end
    r_next.slept = SLEEP;
    if (r_reg.slept && !SLEEP)
    begin
      r_next.wake_pend = 1'b1;
    end

    // ---------------------------------------------------------------
    // Rate measurement on the sync character
    // ---------------------------------------------------------------
    if (ab_on && !SLEEP)
    begin
      if (r_reg.ab_falls != 3'h0)
      begin
        r_next.ab_cnt = r_reg.ab_cnt + 24'h000001;
      end
      if (r_reg.line_prev && !line)
      begin
        r_next.ab_falls = r_reg.ab_falls + 3'h1;
        if (r_reg.ab_falls == 3'h0)
        begin
          r_next.ab_cnt = 24'h000000;
        end
        if (r_next.ab_falls == ufmc_pkg::AB_LAST_FALL)
        begin
          // Five falling edges of the sync pattern span eight bit times.
          if (r_reg.mode[ufmc_pkg::BIT_FAST_OVERSAMPLE_SEL])
          begin
            r_next.div = r_next.ab_cnt[ufmc_pkg::AB_SHIFT_FAST +: 16];
          end
          else
          begin
            r_next.div = r_next.ab_cnt[ufmc_pkg::AB_SHIFT_STD +: 16];
          end
          if (r_next.div == 16'h0000)
          begin
            r_next.div = 16'h0001;
          end
          r_next.mode[ufmc_pkg::BIT_AUTO_RATE_MEASURE_EN] = 1'b0;
          r_next.ab_falls = 3'h0;
          r_next.rx_st = ufmc_pkg::RX_STOP;
          r_next.rx_cnt = 5'h00;
        end
      end
    end
    else
    begin
      r_next.ab_falls = 3'h0;
    end

    // ---------------------------------------------------------------
    // Receiver
    // ---------------------------------------------------------------
    unique case (r_reg.rx_st)
      ufmc_pkg::RX_IDLE:
      begin
        if (!line && !ab_on && !SLEEP)
        begin
          r_next.rx_st = ufmc_pkg::RX_START;
          r_next.rx_cnt = 5'h00;
        end
      end
      ufmc_pkg::RX_START:
      begin
        if (tick)
        begin
          r_next.rx_cnt = r_reg.rx_cnt + 5'h01;
          if (r_reg.rx_cnt == (os >> 1) - 5'h01)
          begin
            r_next.rx_cnt = 5'h00;
            r_next.rx_bit = 4'h0;
            r_next.rx_perr = 1'b0;
            r_next.rx_st = line ? ufmc_pkg::RX_IDLE : ufmc_pkg::RX_DATA;
          end
        end
      end
      ufmc_pkg::RX_DATA:
      begin
        if (tick)
        begin
          r_next.rx_cnt = r_reg.rx_cnt + 5'h01;
          if (r_reg.rx_cnt == os - 5'h01)
          begin
            r_next.rx_cnt = 5'h00;
            r_next.rx_shift = {line, r_reg.rx_shift[8:1]};
            r_next.rx_bit = r_reg.rx_bit + 4'h1;
            if (r_reg.rx_bit == nbits - 4'h1)
            begin
              r_next.rx_st = par_on ? ufmc_pkg::RX_PAR : ufmc_pkg::RX_STOP;
            end
          end
        end
      end
      ufmc_pkg::RX_PAR:
      begin
        if (tick)
        begin
          r_next.rx_cnt = r_reg.rx_cnt + 5'h01;
          if (r_reg.rx_cnt == os - 5'h01)
          begin
            r_next.rx_cnt = 5'h00;
            // Eight data bits have been shifted into the upper lanes.
            r_next.rx_perr = (^{r_reg.rx_shift[8:1], line}) ^ (pd == ufmc_pkg::PD_ODD);
            r_next.rx_st = ufmc_pkg::RX_STOP;
          end
        end
      end
      ufmc_pkg::RX_STOP:
      begin
        if (tick)
        begin
          r_next.rx_cnt = r_reg.rx_cnt + 5'h01;
          if (r_reg.rx_cnt == os - 5'h01)
          begin
            r_next.rx_st = ufmc_pkg::RX_IDLE;
            if (!ab_on && r_reg.ab_falls == 3'h0 && r_reg.rx_bit != 4'h0)
            begin
              push = 1'b1;
              word.frame_err = !line;
              word.parity_err = r_reg.rx_perr;
              word.wake_bad = r_reg.wake_pend;
              word.data = (nbits == 4'h9) ? r_reg.rx_shift : {1'b0, r_reg.rx_shift[8:1]};
              r_next.wake_pend = 1'b0;
            end
            r_next.rx_bit = 4'h0;
          end
        end
      end
    endcase

    // ---------------------------------------------------------------
    // Transmitter
    // ---------------------------------------------------------------
    if (tick)
    begin
      r_next.tx_cnt = r_reg.tx_cnt + 5'h01;
      if (r_reg.tx_cnt == os - 5'h01)
      begin
        r_next.tx_cnt = 5'h00;
        unique case (r_reg.tx_st)
          ufmc_pkg::TX_IDLE:
          begin
            r_next.tx_out = 1'b1;
          end
          ufmc_pkg::TX_START:
          begin
            r_next.tx_out = 1'b0;
            r_next.tx_bit = 4'h0;
            r_next.tx_st = ufmc_pkg::TX_DATA;
          end
          ufmc_pkg::TX_DATA:
          begin
            r_next.tx_out = r_reg.tx_shift[r_reg.tx_bit];
            r_next.tx_bit = r_reg.tx_bit + 4'h1;
            if (r_reg.tx_bit == nbits - 4'h1)
            begin
              r_next.tx_st = par_on ? ufmc_pkg::TX_PAR : ufmc_pkg::TX_STOP;
              r_next.tx_bit = 4'h0;
            end
          end
          ufmc_pkg::TX_PAR:
          begin
            r_next.tx_out = (^r_reg.tx_shift[7:0]) ^ (pd == ufmc_pkg::PD_ODD);
            r_next.tx_st = ufmc_pkg::TX_STOP;
          end
          ufmc_pkg::TX_STOP:
          begin
            r_next.tx_out = 1'b1;
            r_next.tx_bit = r_reg.tx_bit + 4'h1;
            if (r_reg.tx_bit == {3'h0, r_reg.mode[ufmc_pkg::BIT_STOP_COUNT_SEL]})
            begin
              r_next.tx_st = ufmc_pkg::TX_IDLE;
            end
          end
        endcase
      end
    end

    // ---------------------------------------------------------------
    // Avalon-MM slave: one wait cycle; a TXD write to a busy transmitter waits until it is idle
    // ---------------------------------------------------------------
    req = AVS_READ || AVS_WRITE;
    accept = r_reg.resp && !(AVS_WRITE && AVS_ADDRESS == ufmc_pkg::OFS_TXD && r_reg.tx_st != ufmc_pkg::TX_IDLE);
    r_next.resp = req && !accept;
    pop = accept && AVS_READ && AVS_ADDRESS == ufmc_pkg::OFS_RXD && r_reg.fill != 2'h0;
    if (req && !r_reg.resp)
    begin
      unique case (AVS_ADDRESS)
        ufmc_pkg::OFS_MODE: r_next.rdata = {16'h0000, r_reg.mode};
        ufmc_pkg::OFS_DIV: r_next.rdata = {16'h0000, r_reg.div};
        ufmc_pkg::OFS_STAT: r_next.rdata = {23'h000000, r_reg.st_ovr, r_reg.st_wake, r_reg.st_perr,
          r_reg.st_ferr, r_reg.tx_st != ufmc_pkg::TX_IDLE, ab_on, r_reg.fill};
        ufmc_pkg::OFS_RXD: r_next.rdata = {20'h00000, r_reg.buf0};
        default: r_next.rdata = 32'h00000000;
      endcase
    end
    if (accept && AVS_WRITE)
    begin
      unique case (AVS_ADDRESS)
        ufmc_pkg::OFS_MODE:
        begin
          r_next.mode = merge16(r_next.mode, AVS_WRITEDATA, AVS_BYTEENABLE) & ufmc_pkg::MODE_MASK;
          r_next.ab_falls = 3'h0;
        end
        ufmc_pkg::OFS_DIV:
        begin
          r_next.div = merge16(r_reg.div, AVS_WRITEDATA, AVS_BYTEENABLE);
          if (r_next.div == 16'h0000)
          begin
            r_next.div = 16'h0001;
          end
        end
        ufmc_pkg::OFS_TXD:
        begin
          r_next.tx_shift = AVS_WRITEDATA[8:0];
          r_next.tx_st = ufmc_pkg::TX_START;
        end
        ufmc_pkg::OFS_STAT:
        begin
          r_next.st_ferr = r_reg.st_ferr && !AVS_WRITEDATA[4];
          r_next.st_perr = r_reg.st_perr && !AVS_WRITEDATA[5];
          r_next.st_wake = r_reg.st_wake && !AVS_WRITEDATA[6];
          r_next.st_ovr = r_reg.st_ovr && !AVS_WRITEDATA[7];
        end
        default:
        begin
        end
      endcase
    end

    // ---------------------------------------------------------------
    // Two-entry receive buffer; sticky flags set after any clear
    // ---------------------------------------------------------------
    if (pop)
    begin
      r_next.buf0 = r_reg.buf1;
      r_next.fill = r_reg.fill - 2'h1;
    end
    if (push)
    begin
      if (r_next.fill == 2'h0)
      begin
        r_next.buf0 = word;
        r_next.fill = 2'h1;
      end
      else if (r_next.fill == 2'h1)
      begin
        r_next.buf1 = word;
        r_next.fill = 2'h2;
      end
      else
      begin
        r_next.st_ovr = 1'b1;
      end
      r_next.st_ferr = r_next.st_ferr || word.frame_err;
      r_next.st_perr = r_next.st_perr || word.parity_err;
      r_next.st_wake = r_next.st_wake || word.wake_bad;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      r_reg <= '0;
      r_reg.sync1 <= 1'b1;
      r_reg.sync2 <= 1'b1;
      r_reg.line_prev <= 1'b1;
      r_reg.tx_out <= 1'b1;
      r_reg.mode <= ufmc_pkg::MODE_RST;
      r_reg.div <= RESET_DIVISOR;
      r_reg.rx_st <= ufmc_pkg::RX_IDLE;
      r_reg.tx_st <= ufmc_pkg::TX_IDLE;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !accept;
  assign AVS_READDATA = r_reg.rdata;
  assign SERIAL_TRANSMIT_PIN = r_reg.tx_out;

endmodule

// File: common/ufmc_pkg.sv
/*
  Constants and types of the serial frame mode controller: register
  offsets, mode field positions, reset values and the state record.
  Assumes a 32-bit Avalon-MM slave port addressed in bytes.
*/
package ufmc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFS_MODE = 5'h00;
  localparam logic [4:0] OFS_DIV = 5'h04;
  localparam logic [4:0] OFS_STAT = 5'h08;
  localparam logic [4:0] OFS_TXD = 5'h0C;
  localparam logic [4:0] OFS_RXD = 5'h10;

  // ---------------------------------------------------------------
  // Mode register fields
  // ---------------------------------------------------------------
  localparam int BIT_AUTO_RATE_MEASURE_EN = 5;
  localparam int BIT_RXINV = 4;
  localparam int BIT_FAST_OVERSAMPLE_SEL = 3;
  localparam int PARITY_WIDTH_SEL_LO = 1;
  localparam int BIT_STOP_COUNT_SEL = 0;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] MODE_MASK = 16'h003F;
  localparam logic [1:0] PD_NINE = 2'h3;
  localparam logic [1:0] PD_ODD = 2'h2;
  localparam logic [1:0] PD_EVEN = 2'h1;

  // ---------------------------------------------------------------
  // Timing and measurement
  // ---------------------------------------------------------------
  localparam logic [4:0] OS_STD = 5'h10;
  localparam logic [4:0] OS_FAST = 5'h04;
  localparam logic [7:0] SYNC_CHAR = 8'h55;
  localparam logic [2:0] AB_LAST_FALL = 3'h5;
  localparam int AB_SHIFT_STD = 7;
  localparam int AB_SHIFT_FAST = 5;
  localparam int BUF_DEPTH = 2;

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ufmc_rx_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ufmc_tx_t;

  typedef struct packed {
    logic frame_err;
    logic parity_err;
    logic wake_bad;
    logic [8:0] data;
  } ufmc_word_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic line_prev;
    logic [15:0] mode;
    logic [15:0] div;
    logic [15:0] bcnt;
    ufmc_rx_t rx_st;
    logic [4:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [8:0] rx_shift;
    logic rx_perr;
    ufmc_tx_t tx_st;
    logic [4:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [8:0] tx_shift;
    logic tx_out;
    logic [2:0] ab_falls;
    logic [23:0] ab_cnt;
    logic slept;
    logic wake_pend;
    ufmc_word_t buf0;
    ufmc_word_t buf1;
    logic [1:0] fill;
    logic st_ferr;
    logic st_perr;
    logic st_wake;
    logic st_ovr;
    logic resp;
    logic [31:0] rdata;
  } ufmc_state_t;

endpackage

// File: tb/ufmc_partner.sv
/*
  Remote serial node: sends frames on the device's receive line.
  Assumes one caller at a time and the bench clock as its time base.
*/
`timescale 1ns/1ps
module ufmc_partner (
  input wire logic clk,
  input wire logic inv,
  output logic line
);
  logic drive = 1'h1;
  assign line = drive ^ inv;
  task automatic bit_out(input logic v, input int bt);
    drive <= v;
    repeat (bt) @(posedge clk);
  endtask
  // A wrong parity bit is sent only when the caller asks for one.
  task automatic send(input logic [8:0] d, input int nb, input int par, input logic bad, input int stops,
    input int bt);
    int i;
    bit_out(1'h0, bt);
    for (i = 0; i < nb; i++)
      bit_out(d[i], bt);
    if (par != 0)
      bit_out((^d[7:0]) ^ (par == 2) ^ bad, bt);
    for (i = 0; i < stops; i++)
      bit_out(1'h1, bt);
  endtask
endmodule

// File: tb/ufmc_assertions.sv
/*
  Checker of the controller's bus answers and serial output.
  Assumes it is bound into every ufmc_top instance.
*/
`timescale 1ns/1ps
module ufmc_checker (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic SLEEP,
  input wire logic [ufmc_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic SERIAL_TRANSMIT_PIN
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);
  logic rd_done;
  assign rd_done = AVS_READ && !AVS_WAITREQUEST;
  AST_RESET_IDLE: assert property ($fell(SRST) |-> SERIAL_TRANSMIT_PIN && AVS_READDATA == 32'h0)
    else $error("Outputs not idle after reset.");
  AST_IDLE_NO_WAIT: assert property (!AVS_READ && !AVS_WRITE |-> !AVS_WAITREQUEST)
    else $error("Wait asserted without a request.");
  AST_FIRST_WAIT: assert property ($rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST)
    else $error("Request answered in its first cycle.");
  AST_READ_ANSWER: assert property ($rose(AVS_READ) |=> !AVS_WAITREQUEST)
    else $error("Read not answered in the second cycle.");
  AST_WRITE_ANSWER: assert property ($rose(AVS_WRITE) && AVS_ADDRESS != ufmc_pkg::OFS_TXD |=> !AVS_WAITREQUEST)
    else $error("Write not answered in the second cycle.");
  AST_UNMAPPED_ZERO: assert property (rd_done && (AVS_ADDRESS[1:0] != 2'h0 || AVS_ADDRESS > ufmc_pkg::OFS_RXD)
    |-> AVS_READDATA == 32'h0) else $error("Unmapped read not zero.");
  AST_MODE_FIELDS: assert property (rd_done && AVS_ADDRESS == ufmc_pkg::OFS_MODE |-> AVS_READDATA[31:6] == 26'h0)
    else $error("Mode upper bits not zero.");
  AST_STAT_FIELDS: assert property (rd_done && AVS_ADDRESS == ufmc_pkg::OFS_STAT |-> AVS_READDATA[31:8] == 24'h0)
    else $error("Status upper bits not zero.");
  AST_SLEEP_FREEZE: assert property (SLEEP |=> $stable(SERIAL_TRANSMIT_PIN))
    else $error("Serial output moved in sleep.");
  cover property (rd_done && AVS_ADDRESS == ufmc_pkg::OFS_RXD);
  cover property (SLEEP && !SERIAL_TRANSMIT_PIN);
  cover property ($rose(AVS_WRITE) && AVS_ADDRESS == ufmc_pkg::OFS_TXD);
endmodule
bind ufmc_top ufmc_checker i_ufmc_checker (.CLK(CLK), .SRST(SRST), .SLEEP(SLEEP), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .SERIAL_TRANSMIT_PIN(SERIAL_TRANSMIT_PIN));

// File: tb/uart_frame_mode_control_bench.sv
/*
  Self-checking bench: register bus, every receive format, buffer,
  rate measurement and sleep. Assumes the partner and checker files.
*/
`timescale 1ns/1ps
module uart_frame_mode_control_bench;
  logic CLK = 1'h0;
  logic SRST = 1'h1;
  logic SLEEP = 1'h0;
  logic [4:0] AVS_ADDRESS = 5'h00;
  logic AVS_READ = 1'h0;
  logic AVS_WRITE = 1'h0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  logic rx_line;
  logic tx_pin;
  logic line_inv = 1'h0;
  logic [31:0] q;
  logic [8:0] d;
  int failures = 0;
  int n_compared = 0;
  int seed = 52;
  int bt = 32;
  int exp_q[$];
  ufmc_top i_ufmc_top (.CLK(CLK), .SRST(SRST), .SLEEP(SLEEP), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .SERIAL_RECEIVE_PIN(rx_line), .SERIAL_TRANSMIT_PIN(tx_pin));
  ufmc_partner i_ufmc_partner (.clk(CLK), .inv(line_inv), .line(rx_line));
  initial
  begin
    forever #12.5 CLK = ~CLK;
  end
  task automatic complete_run();
    if (failures == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // The request is held until the rising edge at which waitrequest is sampled low.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    AVS_ADDRESS <= a;
    AVS_WRITE <= w;
    AVS_READ <= ~w;
    AVS_WRITEDATA <= wd;
    @(posedge CLK);
    while (AVS_WAITREQUEST !== 1'h0)
    begin
      n++;
      if (n > 200)
      begin
        failures++;
        complete_run();
      end
      @(posedge CLK);
    end
    q = AVS_READDATA;
    AVS_READ <= 1'h0;
    AVS_WRITE <= 1'h0;
    @(posedge CLK);
  endtask
  task automatic rst(input logic inv);
    SRST <= 1'h1;
    line_inv <= 1'h0;
    repeat (10) @(posedge CLK);
    SRST <= 1'h0;
    @(posedge CLK);
    bus(1'h0, ufmc_pkg::OFS_MODE, 32'h0);
    chk(q, 32'h0);
    bus(1'h0, ufmc_pkg::OFS_DIV, 32'h0);
    chk(q, 32'h1);
    // The line idle level follows the polarity only once the mode holds it.
    bus(1'h1, ufmc_pkg::OFS_MODE, {27'h0, inv, 4'h0});
    line_inv <= inv;
    repeat (40) @(posedge CLK);
  endtask
  task automatic rx_one(input logic [5:0] m, input logic bad, input logic wake);
    int nb;
    int par;
    d = 9'($random(seed));
    nb = (m[2:1] == 2'h3) ? 9 : 8;
    par = (m[2:1] == 2'h3) ? 0 : int'(m[2:1]);
    exp_q.push_back(int'({bad, wake, (nb == 9) ? d : {1'h0, d[7:0]}}));
    i_ufmc_partner.send(d, nb, par, bad, int'(m[0]) + 1, bt);
    repeat (bt) @(posedge CLK);
  endtask
  task automatic rd_rx();
    bus(1'h0, ufmc_pkg::OFS_RXD, 32'h0);
    chk(q, 32'(exp_q.pop_front()));
  endtask
  initial
  begin
    int w;
    for (int m = 0; m < 32; m++)
    begin
      if (m[3:0] == 0)
      begin
        rst(m[4]);
        bus(1'h1, 5'h14, 32'hFFFF);
        bus(1'h0, 5'h14, 32'h0);
        chk(q, 32'h0);
        bus(1'h1, ufmc_pkg::OFS_DIV, 32'h2);
      end
      bus(1'h1, ufmc_pkg::OFS_MODE, 32'(m) | 32'hFFC0);
      bus(1'h0, ufmc_pkg::OFS_MODE, 32'h0);
      chk(q, 32'(m));
      bt = m[3] ? 8 : 32;
      rx_one(6'(m), m[0] & (m[2] ^ m[1]), 1'h0);
      rd_rx();
    end
    rst(1'h0);
    bus(1'h1, ufmc_pkg::OFS_DIV, 32'h2);
    bt = 32;
    for (int k = 0; k < 3; k++)
      rx_one(6'h00, 1'h0, 1'h0);
    void'(exp_q.pop_back());
    bus(1'h0, ufmc_pkg::OFS_STAT, 32'h0);
    chk(q, 32'h82);
    repeat (2) rd_rx();
    bus(1'h1, ufmc_pkg::OFS_MODE, 32'h20);
    i_ufmc_partner.send(9'h055, 8, 0, 1'h0, 1, 48);
    repeat (48) @(posedge CLK);
    bus(1'h0, ufmc_pkg::OFS_MODE, 32'h0);
    chk(q, 32'h0);
    bus(1'h0, ufmc_pkg::OFS_DIV, 32'h0);
    chk(q, 32'h3);
    bus(1'h0, ufmc_pkg::OFS_STAT, 32'h0);
    chk(q, 32'h80);
    bt = 48;
    bus(1'h1, ufmc_pkg::OFS_TXD, 32'h1A5);
    w = 0;
    while (tx_pin !== 1'h0 && w < 200)
    begin
      w++;
      @(posedge CLK);
    end
    if (w == 200)
      failures++;
    q = 32'h0;
    repeat (24) @(posedge CLK);
    for (int b = 0; b < 10; b++)
    begin
      q[b] = tx_pin;
      repeat (48) @(posedge CLK);
    end
    chk(q, 32'h34A);
    repeat (10) @(posedge CLK);
    SLEEP <= 1'h1;
    repeat (40) @(posedge CLK);
    SLEEP <= 1'h0;
    for (int k = 0; k < 2; k++)
      rx_one(6'h00, 1'h0, k == 0);
    repeat (2) rd_rx();
    complete_run();
  end
endmodule
